// *** hw/rcd_calendar_date.sv ***
// Calendar date holding register with write-unlock gating
//
// The register addresses and the plain strobed port are this design's own decisions.
`include "rcd_params.svh"

module rcd_calendar_date (
	input wire logic clk_i, // 10 MHz register clock
	input wire logic rst_n_i, // Synchronous reset, active low
	input wire logic [`RCD_ADDR_W-1:0] addr_i, // Register byte address
	input wire logic [31:0] wdata_i, // Write data
	input wire logic wr_i, // Write strobe
	input wire logic rd_i, // Read strobe
	output logic [31:0] rdata_o, // Read data, valid the cycle after rd_i
	output logic calendar_write_unlock_o, // Current write-unlock bit
	output logic [3:0] year_tens_digit_o, // Year tens digit
	output logic [3:0] year_units_digit_o, // Year units digit
	output logic month_tens_digit_o, // Month tens digit
	output logic [3:0] month_units_digit_o, // Month units digit
	output logic [1:0] date_tens_digit_o, // Day-of-month tens digit
	output logic [3:0] date_units_digit_o, // Day-of-month units digit
	output logic [2:0] weekday_number_o // Weekday number
);

	rcd_pkg::rcd_word_t calendar_date_value;
	logic calendar_write_unlock;
	logic date_wr;
	logic ctrl_wr;
	rcd_pkg::rcd_word_t next_rdata;
	logic date_load;
	logic date_loaded;
	rcd_pkg::rcd_access_t access_kind;
	logic write_digits_legal;
	logic held_digits_legal;

	assign date_wr = wr_i && (addr_i == `RCD_OFF_DATE);
	assign ctrl_wr = wr_i && (addr_i == `RCD_OFF_CTRL);
	assign date_load = date_wr && calendar_write_unlock;

	// Control word: only the unlock bit is implemented here
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			calendar_write_unlock <= 1'b0;
		end else if (ctrl_wr) begin
			calendar_write_unlock <= wdata_i[`RCD_UNLOCK_BIT];
		end
	end

	// No reset on purpose: the date is undefined until software loads it
	always_ff @(posedge clk_i) begin
		if (date_wr && calendar_write_unlock) begin
			calendar_date_value <= wdata_i & `RCD_DATE_IMPL_MASK;
		end
	end

	always_comb begin
		next_rdata = 32'h00000000;
		case (addr_i)
			`RCD_OFF_DATE: next_rdata = calendar_date_value & `RCD_DATE_IMPL_MASK;
			`RCD_OFF_CTRL: next_rdata[`RCD_UNLOCK_BIT] = calendar_write_unlock;
			default: next_rdata = 32'h00000000;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rdata_o <= 32'h00000000;
		end else if (rd_i) begin
			rdata_o <= next_rdata;
		end else begin
			rdata_o <= 32'h00000000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			calendar_write_unlock_o <= 1'b0;
		end else begin
			calendar_write_unlock_o <= (ctrl_wr) ? wdata_i[`RCD_UNLOCK_BIT] : calendar_write_unlock;
		end
	end

	// Field outputs mirror the register; written fields appear with the stored value
	always_ff @(posedge clk_i) begin
		if (date_wr && calendar_write_unlock) begin
			year_tens_digit_o <= wdata_i[`RCD_YEAR_TENS_HI:`RCD_YEAR_TENS_LO];
			year_units_digit_o <= wdata_i[`RCD_YEAR_UNITS_HI:`RCD_YEAR_UNITS_LO];
			month_tens_digit_o <= wdata_i[`RCD_MONTH_TENS_BIT];
			month_units_digit_o <= wdata_i[`RCD_MONTH_UNITS_HI:`RCD_MONTH_UNITS_LO];
			date_tens_digit_o <= wdata_i[`RCD_DATE_TENS_HI:`RCD_DATE_TENS_LO];
			date_units_digit_o <= wdata_i[`RCD_DATE_UNITS_HI:`RCD_DATE_UNITS_LO];
			weekday_number_o <= wdata_i[`RCD_WEEKDAY_HI:`RCD_WEEKDAY_LO];
		end
	end

	// Assertion helper: set by the first accepted date write, so no check compares unknown contents
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			date_loaded <= 1'b0;
		end else if (date_load) begin
			date_loaded <= 1'b1;
		end
	end

	// Assertion helper: kind of access this cycle; the master never raises both strobes
	always_comb begin
		access_kind = rcd_pkg::RCD_ACC_NONE;
		if (wr_i) begin
			access_kind = rcd_pkg::RCD_ACC_WRITE;
		end else if (rd_i) begin
			access_kind = rcd_pkg::RCD_ACC_READ;
		end
	end

	// Illegal digits are stored as written, so legality is only promised after legal writes
	always_comb begin
		write_digits_legal = (wdata_i[`RCD_YEAR_TENS_HI:`RCD_YEAR_TENS_LO] <= `RCD_BCD_DIGIT_MAX)
			&& (wdata_i[`RCD_YEAR_UNITS_HI:`RCD_YEAR_UNITS_LO] <= `RCD_BCD_DIGIT_MAX)
			&& (wdata_i[`RCD_MONTH_UNITS_HI:`RCD_MONTH_UNITS_LO] <= `RCD_BCD_DIGIT_MAX)
			&& (wdata_i[`RCD_DATE_UNITS_HI:`RCD_DATE_UNITS_LO] <= `RCD_BCD_DIGIT_MAX)
			&& (wdata_i[`RCD_WEEKDAY_HI:`RCD_WEEKDAY_LO] <= `RCD_WEEKDAY_MAX);
	end

	always_comb begin
		held_digits_legal = (year_tens_digit_o <= `RCD_BCD_DIGIT_MAX)
			&& (year_units_digit_o <= `RCD_BCD_DIGIT_MAX)
			&& (month_units_digit_o <= `RCD_BCD_DIGIT_MAX)
			&& (date_units_digit_o <= `RCD_BCD_DIGIT_MAX)
			&& (weekday_number_o <= `RCD_WEEKDAY_MAX);
	end

	// Steps of a software date update, shared by the load, read-back and lock-then-write checks
	sequence seq_date_load;
		date_load;
	endsequence

	sequence seq_date_blocked;
		date_loaded && date_wr && !calendar_write_unlock;
	endsequence

	sequence seq_lock_write;
		date_loaded && ctrl_wr && !wdata_i[`RCD_UNLOCK_BIT];
	endsequence

	sequence seq_bus_idle;
		access_kind == rcd_pkg::RCD_ACC_NONE;
	endsequence

	sequence seq_date_read;
		access_kind == rcd_pkg::RCD_ACC_READ && addr_i == `RCD_OFF_DATE;
	endsequence

	sequence seq_ctrl_read;
		access_kind == rcd_pkg::RCD_ACC_READ && addr_i == `RCD_OFF_CTRL;
	endsequence

	chk_locked_write_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(date_loaded && date_wr && !calendar_write_unlock) |=> $stable(calendar_date_value))
		else $error("date changed on a locked write");

	chk_unlocked_write_loads: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(date_wr && calendar_write_unlock) |=> calendar_date_value == ($past(wdata_i) & `RCD_DATE_IMPL_MASK))
		else $error("unlocked date write not stored");

	chk_unused_read_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(rd_i && addr_i == `RCD_OFF_DATE) |=> (rdata_o & ~`RCD_DATE_IMPL_MASK) == 32'h00000000)
		else $error("unused date bits read nonzero");

	chk_year_field_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(date_loaded && rd_i && addr_i == `RCD_OFF_DATE) |=> rdata_o[31:24] == {year_tens_digit_o, year_units_digit_o})
		else $error("year digits read back wrong");

	chk_month_field_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(date_loaded && rd_i && addr_i == `RCD_OFF_DATE) |=> rdata_o[20:16] == {month_tens_digit_o, month_units_digit_o})
		else $error("month digits read back wrong");

	chk_date_field_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(date_loaded && rd_i && addr_i == `RCD_OFF_DATE) |=> rdata_o[13:8] == {date_tens_digit_o, date_units_digit_o})
		else $error("date digits read back wrong");

	chk_weekday_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(date_loaded && rd_i && addr_i == `RCD_OFF_DATE) |=> rdata_o[2:0] == weekday_number_o)
		else $error("weekday read back wrong");

	chk_read_one_cycle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!rd_i |=> rdata_o == 32'h00000000)
		else $error("read data stands without a read");

	chk_unlock_follows: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ctrl_wr |=> calendar_write_unlock_o == $past(wdata_i[`RCD_UNLOCK_BIT]))
		else $error("unlock bit did not follow control write");

	property p_year_digits_load;
		@(posedge clk_i) disable iff (!rst_n_i)
		seq_date_load |=> {year_tens_digit_o, year_units_digit_o}
			== $past(wdata_i[`RCD_YEAR_TENS_HI:`RCD_YEAR_UNITS_LO]);
	endproperty
	chk_year_digits_load: assert property (p_year_digits_load)
		else $error("year digits not loaded from write data");

	property p_month_digits_load;
		@(posedge clk_i) disable iff (!rst_n_i)
		seq_date_load |=> {month_tens_digit_o, month_units_digit_o}
			== $past(wdata_i[`RCD_MONTH_TENS_BIT:`RCD_MONTH_UNITS_LO]);
	endproperty
	chk_month_digits_load: assert property (p_month_digits_load)
		else $error("month digits not loaded from write data");

	property p_date_digits_load;
		@(posedge clk_i) disable iff (!rst_n_i)
		seq_date_load |=> {date_tens_digit_o, date_units_digit_o}
			== $past(wdata_i[`RCD_DATE_TENS_HI:`RCD_DATE_UNITS_LO]);
	endproperty
	chk_date_digits_load: assert property (p_date_digits_load)
		else $error("day digits not loaded from write data");

	property p_weekday_load;
		@(posedge clk_i) disable iff (!rst_n_i)
		seq_date_load |=> weekday_number_o == $past(wdata_i[`RCD_WEEKDAY_HI:`RCD_WEEKDAY_LO]);
	endproperty
	chk_weekday_load: assert property (p_weekday_load)
		else $error("weekday not loaded from write data");

	property p_write_read_back;
		@(posedge clk_i) disable iff (!rst_n_i)
		seq_date_load ##1 seq_bus_idle ##1 seq_date_read |=> rdata_o == ($past(wdata_i, 3) & `RCD_DATE_IMPL_MASK);
	endproperty
	chk_write_read_back: assert property (p_write_read_back)
		else $error("date read after unlocked write differs");

	property p_locked_read_back;
		@(posedge clk_i) disable iff (!rst_n_i)
		seq_date_blocked ##1 seq_bus_idle ##1 seq_date_read |=> rdata_o == ($past(calendar_date_value, 3) & `RCD_DATE_IMPL_MASK);
	endproperty
	chk_locked_read_back: assert property (p_locked_read_back)
		else $error("date read after locked write changed");

	property p_fields_hold;
		@(posedge clk_i) disable iff (!rst_n_i)
		(date_loaded && !date_load) |=> $stable({year_tens_digit_o, year_units_digit_o, month_tens_digit_o,
			month_units_digit_o, date_tens_digit_o, date_units_digit_o, weekday_number_o});
	endproperty
	chk_fields_hold: assert property (p_fields_hold)
		else $error("date fields moved without an accepted write");

	property p_unlock_holds;
		@(posedge clk_i) disable iff (!rst_n_i)
		!ctrl_wr |=> $stable(calendar_write_unlock_o);
	endproperty
	chk_unlock_holds: assert property (p_unlock_holds)
		else $error("unlock bit moved without a control write");

	property p_ctrl_read_bits;
		@(posedge clk_i) disable iff (!rst_n_i)
		seq_ctrl_read |=> rdata_o == {28'h0000000, calendar_write_unlock_o, 3'h0};
	endproperty
	chk_ctrl_read_bits: assert property (p_ctrl_read_bits)
		else $error("control read shows wrong bits");

	property p_unmapped_read_zero;
		@(posedge clk_i) disable iff (!rst_n_i)
		(access_kind == rcd_pkg::RCD_ACC_READ && addr_i != `RCD_OFF_DATE && addr_i != `RCD_OFF_CTRL)
			|=> rdata_o == 32'h00000000;
	endproperty
	chk_unmapped_read_zero: assert property (p_unmapped_read_zero)
		else $error("unmapped read returned nonzero");

	property p_legal_digits_kept;
		@(posedge clk_i) disable iff (!rst_n_i)
		(date_load && write_digits_legal) |=> held_digits_legal;
	endproperty
	chk_legal_digits_kept: assert property (p_legal_digits_kept)
		else $error("legal digits written but illegal digits held");

	property p_legal_digits_stay;
		@(posedge clk_i) disable iff (!rst_n_i)
		(date_loaded && held_digits_legal && !date_load) |=> held_digits_legal;
	endproperty
	chk_legal_digits_stay: assert property (p_legal_digits_stay)
		else $error("held digits became illegal without a write");

	property p_reset_clears;
		@(posedge clk_i)
		!rst_n_i |=> (rdata_o == 32'h00000000) && !calendar_write_unlock_o;
	endproperty
	chk_reset_clears: assert property (p_reset_clears)
		else $error("reset did not clear read data and unlock");

	property p_unused_write_dropped;
		@(posedge clk_i) disable iff (!rst_n_i)
		seq_date_load |=> (calendar_date_value & ~`RCD_DATE_IMPL_MASK) == 32'h00000000;
	endproperty
	chk_unused_write_dropped: assert property (p_unused_write_dropped)
		else $error("unused date bits stored a write");

	property p_locked_keeps_unlock;
		@(posedge clk_i) disable iff (!rst_n_i)
		(date_wr && !calendar_write_unlock) |=> $stable(calendar_write_unlock_o);
	endproperty
	chk_locked_keeps_unlock: assert property (p_locked_keeps_unlock)
		else $error("locked date write touched the unlock bit");

	property p_read_keeps_date;
		@(posedge clk_i) disable iff (!rst_n_i)
		(date_loaded && access_kind == rcd_pkg::RCD_ACC_READ) |=> $stable(calendar_date_value);
	endproperty
	chk_read_keeps_date: assert property (p_read_keeps_date)
		else $error("read changed the stored date");

	property p_unmapped_write_ignored;
		@(posedge clk_i) disable iff (!rst_n_i)
		(date_loaded && access_kind == rcd_pkg::RCD_ACC_WRITE && addr_i != `RCD_OFF_DATE && addr_i != `RCD_OFF_CTRL)
			|=> $stable(calendar_date_value) && $stable(calendar_write_unlock_o);
	endproperty
	chk_unmapped_write_ignored: assert property (p_unmapped_write_ignored)
		else $error("unmapped write changed a register");

	property p_lock_then_write_refused;
		@(posedge clk_i) disable iff (!rst_n_i)
		seq_lock_write ##1 seq_bus_idle ##1 date_wr |=> $stable(calendar_date_value);
	endproperty
	chk_lock_then_write_refused: assert property (p_lock_then_write_refused)
		else $error("date write after lock was accepted");

	property p_read_keeps_unlock;
		@(posedge clk_i) disable iff (!rst_n_i)
		(access_kind == rcd_pkg::RCD_ACC_READ) |=> $stable(calendar_write_unlock_o);
	endproperty
	chk_read_keeps_unlock: assert property (p_read_keeps_unlock)
		else $error("read changed the unlock bit");

	property p_ctrl_write_keeps_date;
		@(posedge clk_i) disable iff (!rst_n_i)
		(date_loaded && ctrl_wr) |=> $stable(calendar_date_value);
	endproperty
	chk_ctrl_write_keeps_date: assert property (p_ctrl_write_keeps_date)
		else $error("control write changed the stored date");

endmodule

// *** hw/rcd_params.svh ***
// Offsets, field positions and widths of the calendar date register block
`ifndef RCD_PARAMS_SVH
`define RCD_PARAMS_SVH

`define RCD_ADDR_W 4
`define RCD_OFF_DATE 4'h0
`define RCD_OFF_CTRL 4'h4

`define RCD_YEAR_TENS_HI 31
`define RCD_YEAR_TENS_LO 28
`define RCD_YEAR_UNITS_HI 27
`define RCD_YEAR_UNITS_LO 24
`define RCD_MONTH_TENS_BIT 20
`define RCD_MONTH_UNITS_HI 19
`define RCD_MONTH_UNITS_LO 16
`define RCD_DATE_TENS_HI 13
`define RCD_DATE_TENS_LO 12
`define RCD_DATE_UNITS_HI 11
`define RCD_DATE_UNITS_LO 8
`define RCD_WEEKDAY_HI 2
`define RCD_WEEKDAY_LO 0

`define RCD_DATE_IMPL_MASK 32'hFF1F3F07
`define RCD_UNLOCK_BIT 3
`define RCD_BCD_DIGIT_MAX 4'h9
`define RCD_WEEKDAY_MAX 3'h6

`endif

// *** hw/rcd_pkg.sv ***
// Types shared by the calendar date register block
package rcd_pkg;
	typedef logic [31:0] rcd_word_t;
	typedef enum logic [1:0] {
		RCD_ACC_NONE,
		RCD_ACC_WRITE,
		RCD_ACC_READ
	} rcd_access_t;
endpackage

// *** bench/tb_rtc_calendar_date_register.sv ***
// Self-checking bench for the calendar date register block
`include "rcd_params.svh"
module tb_rtc_calendar_date_register;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [3:0] addr_i = 4'h0;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [31:0] rdata_o;
	logic unl;
	logic [3:0] yt, yu, mu, du;
	logic mt;
	logic [1:0] dt;
	logic [2:0] wd;
	int miscompares = 0;
	int compares = 0;
	int cycles = 0;
	always #50 clk_i = ~clk_i;
	rcd_calendar_date rcd_calendar_date_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .calendar_write_unlock_o(unl), .year_tens_digit_o(yt),
		.year_units_digit_o(yu), .month_tens_digit_o(mt), .month_units_digit_o(mu), .date_tens_digit_o(dt),
		.date_units_digit_o(du), .weekday_number_o(wd));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
		#1;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, e);
	endtask
	task automatic fld(input logic [31:0] e);
		chk({yt, yu, 3'h0, mt, mu, 2'h0, dt, du, 5'h0, wd}, e);
	endtask
	task tally_and_finish;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Ceiling well above the roughly 61 cycles the sequence needs
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1'b1;
		#1 chk({31'h0, unl}, 32'h0);
		rd(`RCD_OFF_CTRL, 32'h0);
		wr(`RCD_OFF_CTRL, 32'hFFFFFFFF);
		chk({31'h0, unl}, 32'h1);
		rd(`RCD_OFF_CTRL, 32'h8);
		wr(`RCD_OFF_DATE, 32'h98F2F1FE);
		fld(32'h98123106);
		rd(`RCD_OFF_DATE, 32'h98123106);
		@(posedge clk_i);
		#1 chk(rdata_o, 32'h0);
		for (int i = 0; i < 7; i++) begin
			wr(`RCD_OFF_DATE, 32'h20093100 | i);
			rd(`RCD_OFF_DATE, 32'h20093100 | i);
		end
		wr(`RCD_OFF_CTRL, 32'h0);
		wr(`RCD_OFF_DATE, 32'h11111101);
		fld(32'h20093106);
		rd(`RCD_OFF_DATE, 32'h20093106);
		wr(4'h8, 32'hFFFFFFFF);
		rd(4'h8, 32'h0);
		rd(`RCD_OFF_CTRL, 32'h0);
		tally_and_finish();
	end
endmodule
